// File: hdl/oms_pkg.sv
// oms_pkg: constants shared by both ends of the mode selector link.
// assumes a 25 MHz clock; the link is plain same-clock logic.
package oms_pkg;

    // ------------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------------
    localparam logic [7:0] OMS_MODE_NONE = 8'h00;
    localparam logic [7:0] OMS_MODE_PP   = 8'h01; // profile_position_mode
    localparam logic [7:0] OMS_MODE_HM   = 8'h06; // homing_mode
    localparam logic [7:0] OMS_MODE_CSP  = 8'h08;
    localparam logic [7:0] OMS_MODE_CSV  = 8'h09;
    localparam logic [7:0] OMS_MODE_CST  = 8'h0A;

    // ------------------------------------------------------------------
    // communications cycle codes
    // ------------------------------------------------------------------
    localparam logic [2:0] OMS_CYC_250  = 3'h0;
    localparam logic [2:0] OMS_CYC_500  = 3'h1;
    localparam logic [2:0] OMS_CYC_1000 = 3'h2;
    localparam logic [2:0] OMS_CYC_2000 = 3'h3;
    localparam logic [2:0] OMS_CYC_4000 = 3'h4;

    // ------------------------------------------------------------------
    // mapping limits and identifiers
    // ------------------------------------------------------------------
    localparam logic [7:0]  OMS_MAP_SMALL_MAX = 8'h14; // 20 bytes
    localparam logic [7:0]  OMS_MAP_LARGE_MAX = 8'h18; // 24 bytes
    localparam logic [15:0] OMS_MAP_VAR       = 16'h1600;
    localparam logic [15:0] OMS_MAP_FIX_LO    = 16'h1701;
    localparam logic [15:0] OMS_MAP_FIX_HI    = 16'h1705;
    localparam logic [2:0]  OMS_POS_SEL_MAX   = 3'h5;

    // ------------------------------------------------------------------
    // error codes (major.minor packed as two hex digits each)
    // ------------------------------------------------------------------
    localparam logic [15:0] OMS_ERR_NONE = 16'h0000;
    localparam logic [15:0] OMS_ERR_CMD  = 16'h5B01; // 91.1
    localparam logic [15:0] OMS_ERR_FUNC = 16'h5D04; // 93.4

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int OMS_GAP_US      = 2000; // least spacing of mode changes
    localparam int OMS_GAP_CYCLES  = (OMS_GAP_US * (CLK_HZ / 1_000_000));

    // ------------------------------------------------------------------
    // avalon register map of the controller end (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] OMS_REG_CTRL   = 4'h0;
    localparam logic [3:0] OMS_REG_MODE   = 4'h4;
    localparam logic [3:0] OMS_REG_STATUS = 4'h8;
    localparam logic [3:0] OMS_REG_ERROR  = 4'hC;

endpackage

// File: hdl/oms_link_if.sv
// oms_link_if: the process-data link between the master and the drive.
// assumes both ends share clk; the bench instantiates and joins them.
`timescale 1ns/1ps
interface oms_link_if;
    logic        req_vld;   // one-cycle pulse: new mode request
    logic [7:0]  req_mode;
    logic [31:0] req_cmd;   // matching command value
    logic        cyc_tick;  // one-cycle communications cycle boundary
    logic [2:0]  cyc_code;
    logic [7:0]  map_bytes;
    logic [15:0] map_id;
    logic        gear_one;
    logic        warn_data;
    logic        rsp_vld;
    logic        rsp_ok;
    logic [15:0] rsp_err;
    logic [7:0]  disp_mode;
    logic        homing_err;

    modport drive (
        input  req_vld, req_mode, req_cmd, cyc_tick, cyc_code,
               map_bytes, map_id, gear_one, warn_data,
        output rsp_vld, rsp_ok, rsp_err, disp_mode, homing_err
    );
    modport master (
        output req_vld, req_mode, req_cmd, cyc_tick, cyc_code,
               map_bytes, map_id, gear_one, warn_data,
        input  rsp_vld, rsp_ok, rsp_err, disp_mode, homing_err
    );
endinterface

// File: hdl/oms_drive.sv
// oms_drive: device end; validates mode requests, applies them at the next
// cycle boundary, shows the mode in effect and gates control functions.
// assumes link inputs are same-clock logic from the master end.
`timescale 1ns/1ps

module oms_drive
    import oms_pkg::*;
#(
    parameter int GAP_CYCLES = OMS_GAP_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    oms_link_if.drive        link,
    input  wire logic        op_enabled,
    input  wire logic        fault_stop,
    input  wire logic [2:0]  pos_ctrl_sel,
    input  wire logic        autotune_en,
    input  wire logic        ffwd_force_req,
    input  wire logic        spd_obs_req,
    input  wire logic        dist_obs_req,
    input  wire logic [1:0]  adapt_cnt,
    input  wire logic [31:0] target_pos,
    input  wire logic [31:0] target_vel,
    output logic [31:0]      active_cmd,
    output logic             fir_en,
    output logic             damp_en,
    output logic             spd_ffwd_en,
    output logic             smooth_en,
    output logic             force_ffwd_en,
    output logic             spd_obs_en,
    output logic             dist_obs_en,
    output logic             notch3_auto,
    output logic             notch4_auto
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  mode;       // mode in effect
        logic [7:0]  pend_mode;
        logic        pend;
        logic [31:0] gap_cnt;
        logic        rsp_vld;
        logic        rsp_ok;
        logic [15:0] rsp_err;
        logic [7:0]  disp;
        logic        hm_err;
        logic [31:0] cmd;
        logic [8:0]  fn;
    } oms_drv_t;

    oms_drv_t st_ff;
    oms_drv_t nxt_st;

    function automatic logic is_cyclic(input logic [7:0] m);
        return (m == OMS_MODE_CSP) || (m == OMS_MODE_CSV) ||
               (m == OMS_MODE_CST);
    endfunction

    function automatic logic is_pos(input logic [7:0] m);
        return (m == OMS_MODE_CSP) || (m == OMS_MODE_PP) ||
               (m == OMS_MODE_HM);
    endfunction

    // ------------------------------------------------------------------
    // mode support check against cycle, mapping and gear
    // ------------------------------------------------------------------
    function automatic logic supported(input logic [7:0] m,
                                       input logic [2:0] cyc,
                                       input logic [7:0] bytes,
                                       input logic       gear1);
        logic long_cyc;
        logic ok;
        long_cyc = (cyc >= OMS_CYC_1000) && (cyc <= OMS_CYC_4000);
        ok = 1'b0;
        if (m == OMS_MODE_NONE) begin
            ok = 1'b1;
        end else if (gear1 && bytes <= OMS_MAP_SMALL_MAX) begin
            ok = long_cyc || (is_cyclic(m) &&
                 (cyc == OMS_CYC_250 || cyc == OMS_CYC_500));
        end else if (gear1 && bytes <= OMS_MAP_LARGE_MAX) begin
            ok = long_cyc || (is_cyclic(m) && cyc == OMS_CYC_500);
        end else if (!gear1 && bytes <= OMS_MAP_LARGE_MAX) begin
            ok = long_cyc;
        end
        return ok;
    endfunction

    logic code_ok;
    logic map_ok;
    logic [7:0] eff_mode;

    always_comb begin
        code_ok = (link.req_mode == OMS_MODE_NONE) ||
                  (link.req_mode == OMS_MODE_PP) ||
                  (link.req_mode == OMS_MODE_HM) ||
                  is_cyclic(link.req_mode);
        map_ok = (pos_ctrl_sel > OMS_POS_SEL_MAX) ||
                 (link.map_id == OMS_MAP_VAR) ||
                 ((link.map_id >= OMS_MAP_FIX_LO) &&
                  (link.map_id <= OMS_MAP_FIX_HI));
        eff_mode = (op_enabled && !fault_stop) ? st_ff.mode : OMS_MODE_NONE;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp_vld = 1'b0;
        if (st_ff.gap_cnt != 32'h0) begin
            nxt_st.gap_cnt = st_ff.gap_cnt - 32'h1;
        end
        if (link.cyc_tick && st_ff.pend) begin
            nxt_st.mode = st_ff.pend_mode;
            nxt_st.pend = 1'b0;
        end
        if (link.req_vld) begin
            nxt_st.rsp_vld = 1'b1;
            nxt_st.rsp_ok  = 1'b0;
            nxt_st.hm_err  = 1'b0;
            if (!code_ok || st_ff.gap_cnt != 32'h0) begin
                nxt_st.rsp_err = OMS_ERR_CMD;
            end else if ((link.req_mode == OMS_MODE_HM &&
                          link.cyc_code <= OMS_CYC_500) ||
                         !map_ok ||
                         !supported(link.req_mode, link.cyc_code,
                                    link.map_bytes, link.gear_one)) begin
                nxt_st.rsp_err = OMS_ERR_FUNC;
            end else if (link.warn_data && is_cyclic(link.req_mode)) begin
                nxt_st.rsp_err = OMS_ERR_NONE;
            end else begin
                nxt_st.hm_err = link.warn_data &&
                                (link.req_mode == OMS_MODE_HM);
                nxt_st.rsp_ok    = 1'b1;
                nxt_st.rsp_err   = OMS_ERR_NONE;
                nxt_st.pend      = 1'b1;
                nxt_st.pend_mode = link.req_mode;
                // one less, so a request exactly GAP_CYCLES later is taken
                nxt_st.gap_cnt   = 32'(GAP_CYCLES - 1);
                if (link.cyc_tick) begin
                    nxt_st.mode = link.req_mode;
                    nxt_st.pend = 1'b0;
                end
            end
        end
        nxt_st.disp = eff_mode;
        unique case (eff_mode)
            OMS_MODE_CSV: nxt_st.cmd = target_vel;
            default:      nxt_st.cmd = target_pos;
        endcase
        // function gates: fir, damp, sffwd, smooth, fffwd, sobs, dobs, n3, n4
        nxt_st.fn[0] = is_pos(eff_mode) &&
                       (link.cyc_code >= OMS_CYC_1000);
        nxt_st.fn[1] = is_pos(eff_mode);
        nxt_st.fn[2] = is_pos(eff_mode);
        nxt_st.fn[3] = is_pos(eff_mode);
        nxt_st.fn[4] = ffwd_force_req && !autotune_en &&
                       (eff_mode != OMS_MODE_CST);
        nxt_st.fn[5] = spd_obs_req && !autotune_en &&
                       (eff_mode != OMS_MODE_CST);
        nxt_st.fn[6] = dist_obs_req && !autotune_en && !spd_obs_req &&
                       (eff_mode != OMS_MODE_CST);
        nxt_st.fn[7] = (adapt_cnt != 2'h0);
        nxt_st.fn[8] = (adapt_cnt >= 2'h2);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign link.rsp_vld    = st_ff.rsp_vld;
    assign link.rsp_ok     = st_ff.rsp_ok;
    assign link.rsp_err    = st_ff.rsp_err;
    assign link.disp_mode  = st_ff.disp;
    assign link.homing_err = st_ff.hm_err;
    assign active_cmd      = st_ff.cmd;
    assign fir_en          = st_ff.fn[0];
    assign damp_en         = st_ff.fn[1];
    assign spd_ffwd_en     = st_ff.fn[2];
    assign smooth_en       = st_ff.fn[3];
    assign force_ffwd_en   = st_ff.fn[4];
    assign spd_obs_en      = st_ff.fn[5];
    assign dist_obs_en     = st_ff.fn[6];
    assign notch3_auto     = st_ff.fn[7];
    assign notch4_auto     = st_ff.fn[8];

endmodule

// File: hdl/oms_master.sv
// oms_master: controller end; takes orders over avalon-mm, drives the link,
// generates the cycle tick and reports answers from the drive.
// assumes the drive end shares clk.
`timescale 1ns/1ps
module oms_master
    import oms_pkg::*;
#(
    parameter int TICK_CYCLES = 25
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    oms_link_if.master       link,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    typedef struct packed {
        logic [2:0]  cyc;
        logic [7:0]  bytes;
        logic [15:0] map;
        logic        gear1;
        logic        warn;
        logic [7:0]  mode;
        logic [31:0] cmd;
        logic        req;
        logic        busy;   // waiting for answer
        logic        ok;
        logic [15:0] err;
        logic        hm_err;
        logic [31:0] tick_cnt;
        logic        tick;
        logic [31:0] rdata;
        logic        ack;
    } oms_mst_t;

    oms_mst_t st_ff;
    oms_mst_t nxt_st;

    // ------------------------------------------------------------------
    // register access; one wait cycle, answer at the second edge
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.req = 1'b0;
        nxt_st.ack = 1'b0;
        nxt_st.tick = 1'b0;
        nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;
        if (st_ff.tick_cnt >= TICK_CYCLES - 1) begin
            nxt_st.tick_cnt = 32'h0;
            nxt_st.tick = 1'b1;
        end
        if (link.rsp_vld) begin
            nxt_st.busy   = 1'b0;
            nxt_st.ok     = link.rsp_ok;
            nxt_st.err    = link.rsp_err;
            nxt_st.hm_err = link.homing_err;
        end
        if ((avs_read || avs_write) && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdata = 32'h0;
            unique case (avs_address)
                OMS_REG_CTRL: begin
                    nxt_st.rdata = {3'h0, st_ff.warn, st_ff.gear1, st_ff.cyc,
                                    st_ff.bytes, st_ff.map};
                    if (avs_write) begin
                        nxt_st.map   = avs_writedata[15:0];
                        nxt_st.bytes = avs_writedata[23:16];
                        nxt_st.cyc   = avs_writedata[26:24];
                        nxt_st.gear1 = avs_writedata[27];
                        nxt_st.warn  = avs_writedata[28];
                    end
                end
                OMS_REG_MODE: begin
                    nxt_st.rdata = st_ff.cmd;
                    if (avs_write) begin
                        // command value goes out with the mode
                        nxt_st.mode = avs_writedata[7:0];
                        nxt_st.cmd  = {8'h00, avs_writedata[31:8]};
                        nxt_st.req  = 1'b1;
                        nxt_st.busy = 1'b1;
                    end
                end
                OMS_REG_STATUS: begin
                    nxt_st.rdata = {13'h0, st_ff.hm_err, st_ff.ok,
                                    st_ff.busy, 8'h00, link.disp_mode};
                end
                OMS_REG_ERROR: begin
                    nxt_st.rdata = {16'h0, st_ff.err};
                end
                default: begin
                    nxt_st.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata    = st_ff.rdata;
    assign avs_waitrequest = !st_ff.ack;
    assign link.req_vld    = st_ff.req;
    assign link.req_mode   = st_ff.mode;
    assign link.req_cmd    = st_ff.cmd;
    assign link.cyc_tick   = st_ff.tick;
    assign link.cyc_code   = st_ff.cyc;
    assign link.map_bytes  = st_ff.bytes;
    assign link.map_id     = st_ff.map;
    assign link.gear_one   = st_ff.gear1;
    assign link.warn_data  = st_ff.warn;

endmodule

// File: test/oms_link_sva.sv
// oms_link_sva: answer and spacing checks on the mode selector link.
// assumes it sits beside the link interface, on the link's clock.
`timescale 1ns/1ps
module oms_link_sva
    import oms_pkg::*;
#(
    parameter int GAP = OMS_GAP_CYCLES
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        req_vld,
    input wire logic [7:0]  req_mode,
    input wire logic [2:0]  cyc_code,
    input wire logic [7:0]  map_bytes,
    input wire logic        gear_one,
    input wire logic        warn_data,
    input wire logic        rsp_vld,
    input wire logic        rsp_ok,
    input wire logic [15:0] rsp_err
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic        cyc_m;
    logic        live;
    logic        req_nw;
    logic [15:0] gap_ff;
    assign cyc_m  = req_mode inside {OMS_MODE_CSP, OMS_MODE_CSV, OMS_MODE_CST};
    assign live   = cyc_m || req_mode inside {OMS_MODE_PP, OMS_MODE_HM};
    assign req_nw = req_vld && !warn_data;

    // saturating count since the last accepted change; a 4 cycle margin
    // keeps the check clear of the exact end point of the gap
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            gap_ff <= 16'hFFFF;
        else if (rsp_vld && rsp_ok)
            gap_ff <= 16'h0000;
        else if (gap_ff != 16'hFFFF)
            gap_ff <= gap_ff + 16'h0001;
    end

    // ----
    // properties
    // ----
    property p_rsp_next;
        req_vld |=> rsp_vld;
    endproperty
    a_rsp_next: assert property (p_rsp_next)
        else $error("request without answer");
    property p_rsp_cause;
        rsp_vld |-> $past(req_vld);
    endproperty
    a_rsp_cause: assert property (p_rsp_cause)
        else $error("answer without request");
    property p_bad_code;
        req_vld && !live && req_mode != OMS_MODE_NONE
            |=> !rsp_ok && rsp_err == OMS_ERR_CMD;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("bad mode code not refused");
    property p_hm_short;
        req_nw && req_mode == OMS_MODE_HM && cyc_code <= OMS_CYC_500
            |=> !rsp_ok && rsp_err != OMS_ERR_NONE;
    endproperty
    a_hm_short: assert property (p_hm_short)
        else $error("homing at short cycle accepted");
    property p_gear;
        req_nw && live && !gear_one && cyc_code < OMS_CYC_1000
            |=> !rsp_ok && rsp_err != OMS_ERR_NONE;
    endproperty
    a_gear: assert property (p_gear)
        else $error("geared short cycle accepted");
    property p_big_map;
        req_nw && live && gear_one && cyc_code == OMS_CYC_250
            && map_bytes > OMS_MAP_SMALL_MAX
            && map_bytes <= OMS_MAP_LARGE_MAX
            |=> !rsp_ok && rsp_err != OMS_ERR_NONE;
    endproperty
    a_big_map: assert property (p_big_map)
        else $error("large map at short cycle accepted");
    property p_gap;
        req_nw && gap_ff < GAP - 4 |=> !rsp_ok && rsp_err == OMS_ERR_CMD;
    endproperty
    a_gap: assert property (p_gap)
        else $error("change inside gap accepted");
    property p_warn;
        req_vld && cyc_m && warn_data |=> !rsp_ok;
    endproperty
    a_warn: assert property (p_warn)
        else $error("cyclic change under warning accepted");
    property p_ok_clean;
        rsp_vld && rsp_ok |-> rsp_err == OMS_ERR_NONE;
    endproperty
    a_ok_clean: assert property (p_ok_clean)
        else $error("accepted answer carries an error");
endmodule

// File: test/operation_mode_selector_tb.sv
// operation_mode_selector_tb: joins both ends, drives the avalon side and
// the drive levels, and compares against a mode model.
// assumes one clock; gap and tick counts are shortened for run time.
`timescale 1ns/1ps
module operation_mode_selector_tb
    import oms_pkg::*;
;
    localparam int GAP  = 40;
    localparam int TICK = 10;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        op_enabled = 1'b1;
    logic        fault_stop = 1'b0;
    logic        autotune_en = 1'b0;
    logic        ffwd_force_req = 1'b0;
    logic        spd_obs_req = 1'b0;
    logic        dist_obs_req = 1'b0;
    logic [1:0]  adapt_cnt = 2'h0;
    logic [31:0] target_pos = 32'h0;
    logic [31:0] target_vel = 32'h0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] active_cmd;
    wire  [8:0]  fl;
    logic [31:0] rdv;
    logic [31:0] r;
    logic [7:0]  cur = 8'h00;
    logic [2:0]  ccyc = 3'h0;
    logic [2:0]  pos_sel = 3'h0;
    logic [15:0] mid = OMS_MAP_FIX_LO;
    logic [7:0]  tbl [8] = '{OMS_MODE_PP, OMS_MODE_HM, OMS_MODE_CSP,
        OMS_MODE_CSV, OMS_MODE_CST, 8'h02, 8'h0B, 8'hFF};
    int          seed = 54;
    int          failures = 0;
    int          check_count = 0;
    int          cyc_n = 0;
    int          last_ok = -1000;

    always #20 clk = ~clk;
    always @(posedge clk) cyc_n <= cyc_n + 1;

    oms_link_if link ();
    oms_master #(.TICK_CYCLES(TICK)) oms_master_inst (.clk, .sys_rst,
        .clk_en(1'b1), .link(link), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    oms_drive #(.GAP_CYCLES(GAP)) oms_drive_inst (.clk, .sys_rst,
        .clk_en(1'b1), .link(link), .op_enabled, .fault_stop,
        .pos_ctrl_sel(pos_sel), .autotune_en, .ffwd_force_req, .spd_obs_req,
        .dist_obs_req, .adapt_cnt, .target_pos, .target_vel, .active_cmd,
        .fir_en(fl[8]), .damp_en(fl[7]), .spd_ffwd_en(fl[6]),
        .smooth_en(fl[5]), .force_ffwd_en(fl[4]), .spd_obs_en(fl[3]),
        .dist_obs_en(fl[2]), .notch3_auto(fl[1]), .notch4_auto(fl[0]));
    oms_link_sva #(.GAP(GAP)) oms_link_sva_inst (.clk, .sys_rst,
        .req_vld(link.req_vld), .req_mode(link.req_mode),
        .cyc_code(link.cyc_code), .map_bytes(link.map_bytes),
        .gear_one(link.gear_one), .warn_data(link.warn_data),
        .rsp_vld(link.rsp_vld), .rsp_ok(link.rsp_ok), .rsp_err(link.rsp_err));

    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon cycle; the request stands until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 64) begin
            failures++;
            print_verdict();
        end
    endtask

    // {accepted, error code}; a warning refusal is all zero
    function automatic logic [16:0] model(input logic [7:0] m,
        input logic [2:0] c, input logic [7:0] b, input logic g, w);
        logic cy, lv, sup;
        cy = m inside {OMS_MODE_CSP, OMS_MODE_CSV, OMS_MODE_CST};
        lv = cy || m == OMS_MODE_PP || m == OMS_MODE_HM;
        if (!(lv || m == OMS_MODE_NONE) || cyc_n - last_ok < GAP)
            return {1'b0, OMS_ERR_CMD};
        if (g && b <= OMS_MAP_SMALL_MAX)
            sup = c >= OMS_CYC_1000 || cy;
        else
            sup = b <= OMS_MAP_LARGE_MAX && (c >= OMS_CYC_1000
                || (g && cy && c == OMS_CYC_500));
        if ((lv && !sup) || (pos_sel <= OMS_POS_SEL_MAX &&
            mid != OMS_MAP_VAR &&
            !(mid inside {[OMS_MAP_FIX_LO:OMS_MAP_FIX_HI]})))
            return {1'b0, OMS_ERR_FUNC};
        return (w && cy) ? 17'h0 : {1'b1, OMS_ERR_NONE};
    endfunction

    task automatic gate();
        logic p, t, a;
        logic [8:0] e;
        r = $random(seed);
        {autotune_en, ffwd_force_req, spd_obs_req, dist_obs_req} <= r[3:0];
        adapt_cnt  <= r[5:4];
        target_pos <= $random(seed);
        target_vel <= $random(seed);
        repeat (3) @(posedge clk);
        p = cur inside {OMS_MODE_PP, OMS_MODE_HM, OMS_MODE_CSP};
        t = cur != OMS_MODE_CST;
        a = r[3];
        e = {p && ccyc >= OMS_CYC_1000, p, p, p, r[2] && !a && t,
             r[1] && !a && t, r[0] && !a && !r[1] && t, |r[5:4], r[5]};
        chk({23'h0, fl}, {23'h0, e});
        chk(active_cmd, cur == OMS_MODE_CSV ? target_vel : target_pos);
    endtask

    task automatic req(input logic [7:0] m, input logic [2:0] c,
        input logic [7:0] b, input logic g, w, sh);
        logic [31:0] s;
        logic [16:0] e;
        s = $random(seed);
        ccyc = c;
        target_vel <= 32'h0;
        bus(1'b1, OMS_REG_CTRL, {3'h0, w, g, c, b, mid});
        bus(1'b1, OMS_REG_MODE, {s[23:0], m});
        e = model(m, c, b, g, w);
        if (e[16]) begin
            cur = m;
            last_ok = cyc_n;
        end
        repeat (4) @(posedge clk);
        bus(1'b0, OMS_REG_STATUS, 32'h0);
        s = rdv;
        bus(1'b0, OMS_REG_ERROR, 32'h0);
        chk({15'h0, s[17], rdv[15:0]}, {15'h0, e});
        if (w && m == OMS_MODE_HM) chk({31'h0, s[18]}, 32'h1);
        if (!sh) begin
            repeat (TICK + 3) @(posedge clk);
            bus(1'b0, OMS_REG_STATUS, 32'h0);
            chk({24'h0, rdv[7:0]}, {24'h0, cur});
            if (cur != OMS_MODE_NONE) gate();
            repeat (GAP) @(posedge clk);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #(40 * 30000);
        failures++;
        print_verdict();
    end

    // ----
    // main sequence
    // ----
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, OMS_REG_STATUS, 32'h0);
        chk(rdv, 32'h0);
        bus(1'b1, 4'h6, 32'hFFFFFFFF);
        bus(1'b0, 4'h6, 32'h0);
        chk(rdv, 32'h0);
        req(OMS_MODE_CSP, OMS_CYC_1000, 8'h14, 1'b1, 1'b0, 1'b0);
        req(OMS_MODE_PP, OMS_CYC_250, 8'h14, 1'b1, 1'b0, 1'b0);
        req(OMS_MODE_HM, OMS_CYC_500, 8'h14, 1'b1, 1'b0, 1'b0);
        req(OMS_MODE_CSV, OMS_CYC_250, 8'h15, 1'b1, 1'b0, 1'b0);
        req(OMS_MODE_CST, OMS_CYC_500, 8'h18, 1'b1, 1'b0, 1'b0);
        req(OMS_MODE_CSV, OMS_CYC_500, 8'h14, 1'b0, 1'b0, 1'b0);
        req(OMS_MODE_HM, OMS_CYC_4000, 8'h18, 1'b0, 1'b0, 1'b0);
        req(OMS_MODE_CSV, OMS_CYC_1000, 8'h14, 1'b1, 1'b1, 1'b0);
        req(OMS_MODE_PP, OMS_CYC_2000, 8'h14, 1'b1, 1'b1, 1'b0);
        req(OMS_MODE_HM, OMS_CYC_1000, 8'h14, 1'b1, 1'b1, 1'b0);
        req(OMS_MODE_NONE, OMS_CYC_1000, 8'h14, 1'b1, 1'b0, 1'b0);
        req(8'h07, OMS_CYC_1000, 8'h14, 1'b1, 1'b0, 1'b0);
        req(OMS_MODE_CSV, OMS_CYC_2000, 8'h14, 1'b1, 1'b0, 1'b1);
        req(OMS_MODE_CSP, OMS_CYC_2000, 8'h14, 1'b1, 1'b0, 1'b0);
        mid = 16'h1706;
        req(OMS_MODE_CSP, OMS_CYC_1000, 8'h14, 1'b1, 1'b0, 1'b0);
        pos_sel <= 3'h6;
        req(OMS_MODE_CSP, OMS_CYC_1000, 8'h14, 1'b1, 1'b0, 1'b0);
        pos_sel <= 3'h0;
        mid = OMS_MAP_VAR;
        for (int i = 0; i < 2; i++) begin
            op_enabled <= i[0];
            fault_stop <= i[0];
            repeat (TICK + 3) @(posedge clk);
            bus(1'b0, OMS_REG_STATUS, 32'h0);
            chk({24'h0, rdv[7:0]}, 32'h0);
        end
        fault_stop <= 1'b0;
        for (int k = 0; k < 30; k++) begin
            r = $random(seed);
            req(tbl[r[2:0]], r[5:3] % 3'h5, 8'h01 + r[15:8] % 8'h18,
                r[16], 1'b0, 1'b0);
        end
        print_verdict();
    end
endmodule
